// ---- hdl/thl_host_link.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "thl_cfg.svh"
module thl_host_link #(
   parameter logic [6:0] SLAVE_ADDR = 7'h50
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic host_alert_n_o,
   output logic host_alert_n_oe,
   input wire logic [2:0] alert_source_select,
   input wire logic [15:0] inquiry_wait_limit,
   input wire logic [15:0] result_wait_limit,
   input wire logic rf_resp_pulse,
   input wire logic rf_nv_write_done,
   input wire logic field_present,
   input wire logic rf_busy,
   input wire logic self_diag_err,
   input wire logic [7:0] status_byte,
   input wire logic cmd_done,
   input wire logic tun_event,
   input wire logic tun_crypt,
   input wire logic tun_family,
   input wire logic [11:0] tun_addr,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_first,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic cmd_stop,
   output logic mask_rf,
   output logic mask_fld,
   output logic tun_result_send,
   output logic tun_timeout
);
   import thl_pkg::*;

   thl_main_t q, d;
   logic [1:0] pins;
   logic scl, sda, scl_r, scl_f, start, stop, tick, load, set_rf, set_fld;
   logic clr_all;
   logic [7:0] byte_out;

   thl_stream_if #(.W(9)) push_s ();
   thl_stream_if #(.W(9)) out_s ();

   // Mode bits of the inquiry address upper byte
   function automatic logic [1:0] tun_mode(input logic crypt, input logic family);
      if (!crypt) begin
         tun_mode = `THL_MODE_PLAIN;
      end else if (family) begin
         tun_mode = `THL_MODE_FAMILY;
      end else begin
         tun_mode = `THL_MODE_PRIVATE;
      end
   endfunction : tun_mode

   // Timer limit check
   function automatic logic expired(input logic [15:0] cnt, input logic [15:0] lim);
      expired = (cnt >= lim);
   endfunction : expired

   thl_pin_sync #(.W(2), .RST(2'b11)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin({scl_i, sda_i}),
      .level(pins)
   );

   thl_pair_buf #(.W(9)) u_buf (
      .clk(clk),
      .nrst(nrst),
      .in_s(push_s.dst),
      .out_s(out_s.src)
   );

   // Bus event detection on synchronised levels
   assign scl = pins[1];
   assign sda = pins[0];
   assign scl_r = scl && !q.scl_prev;
   assign scl_f = !scl && q.scl_prev;
   assign start = scl && q.scl_prev && q.sda_prev && !sda;
   assign stop = scl && q.scl_prev && !q.sda_prev && sda;
   assign tick = (q.pre == 7'(`THL_TICK_CYC - 1));

   // Interrupt sources gated by select and mask
   assign set_rf = alert_source_select[`THL_SEL_RF_EN] && !q.mask_rf
      && (alert_source_select[`THL_SEL_RF_SRC] ? rf_nv_write_done : rf_resp_pulse);
   assign set_fld = alert_source_select[`THL_SEL_FLD] && !q.mask_fld
      && field_present && !q.fld_prev;

   // Next transmit byte: forced poll, inquiry header, response stream, status
   always_comb begin
      if (q.poll_fix) begin
         byte_out = {status_byte[7:4], rf_busy ? `THL_NIB_BUSY : `THL_NIB_DIAG};
      end else if (q.hdr_cnt == `THL_HDR_LEN) begin
         byte_out = status_byte;
      end else if (q.hdr_cnt == 2'd2) begin
         byte_out = q.hdr_hi;
      end else if (q.hdr_cnt == 2'd1) begin
         byte_out = q.hdr_lo;
      end else if (tx_valid) begin
         byte_out = tx_data;
      end else begin
         byte_out = status_byte;
      end
   end

   // Main next-state logic
   always_comb begin
      d = q;
      load = 1'b0;
      clr_all = 1'b0;
      d.scl_prev = scl;
      d.sda_prev = sda;
      d.fld_prev = field_present;
      d.alert_prev = q.alert_oe;
      d.push_v = 1'b0;
      d.tx_ready = 1'b0;
      d.cmd_stop = 1'b0;
      d.res_send = 1'b0;
      d.tmo = 1'b0;
      d.pre = tick ? 7'd0 : q.pre + 7'd1;
      unique case (q.st)
         ST_IDLE, ST_WAIT: begin
         end
         ST_ADDR: begin
            if (scl_r) begin
               d.sh = {q.sh[6:0], sda};
               d.bit_cnt = q.bit_cnt + 4'd1;
            end else if (scl_f && q.bit_cnt == 4'd8) begin
               if (q.sh[7:1] == SLAVE_ADDR) begin
                  d.sda_oe = 1'b1;
                  d.rw = q.sh[0];
                  d.st = ST_ADDR_ACK;
                  clr_all = q.sh[0];
               end else begin
                  d.st = ST_WAIT;
               end
            end
         end
         ST_ADDR_ACK: begin
            if (scl_f) begin
               d.sda_oe = 1'b0;
               d.bit_cnt = 4'd0;
               d.first = 1'b1;
               d.second = 1'b0;
               if (q.rw) begin
                  load = 1'b1;
               end else begin
                  d.st = ST_RX;
               end
            end
         end
         ST_RX: begin
            if (scl_r) begin
               d.sh = {q.sh[6:0], sda};
               d.bit_cnt = q.bit_cnt + 4'd1;
            end else if (scl_f && q.bit_cnt == 4'd8) begin
               if (push_s.ready) begin
                  d.sda_oe = 1'b1;
                  d.push_v = 1'b1;
                  d.push_d = {q.first, q.sh};
                  d.st = ST_RX_ACK;
                  if (q.first) begin
                     d.cmd = q.sh;
                  end
                  if (q.second && q.cmd == `THL_CMD_CTRL_WRITE) begin
                     d.mask_rf = q.sh[`THL_WR_MASK_RF];
                     d.mask_fld = q.sh[`THL_WR_MASK_FLD];
                  end
               end else begin
                  d.st = ST_WAIT;
               end
            end
         end
         ST_RX_ACK: begin
            if (scl_f) begin
               d.sda_oe = 1'b0;
               d.bit_cnt = 4'd0;
               d.second = q.first;
               d.first = 1'b0;
               d.st = ST_RX;
            end
         end
         ST_TX: begin
            if (scl_f) begin
               d.bit_cnt = q.bit_cnt + 4'd1;
               if (q.bit_cnt == 4'd7) begin
                  d.sda_oe = 1'b0;
                  d.st = ST_TX_ACK;
               end else begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.sda_oe = !q.sh[6];
               end
            end
         end
         ST_TX_ACK: begin
            if (scl_r) begin
               d.st = sda ? ST_WAIT : ST_TX_ACK;
               d.bit_cnt = sda ? q.bit_cnt : 4'd9;
            end else if (scl_f && q.bit_cnt == 4'd9) begin
               load = 1'b1;
            end
         end
      endcase
      // Load and start driving the next response byte
      if (load) begin
         d.sh = byte_out;
         d.sda_oe = !byte_out[7];
         d.bit_cnt = 4'd0;
         d.st = ST_TX;
         if (q.poll_fix) begin
            d.poll_fix = 1'b0;
         end else if (q.hdr_cnt != 2'd0) begin
            d.hdr_cnt = q.hdr_cnt - 2'd1;
         end else if (tx_valid) begin
            d.tx_ready = 1'b1;
         end
      end
      // End of a transfer
      if (stop && q.st != ST_IDLE) begin
         d.st = ST_IDLE;
         d.sda_oe = 1'b0;
         if (!q.rw && q.st != ST_ADDR && q.st != ST_WAIT) begin
            d.poll_fix = 1'b0;
            d.crd = (q.cmd == `THL_CMD_CTRL_READ);
            if (q.cmd == `THL_CMD_INQUIRY && q.tun_act && q.tm == TM_INQ) begin
               d.tm = TM_OFF;
               d.hdr_cnt = `THL_HDR_LEN;
               d.inq_rsp = 1'b1;
               d.pend_ser = 1'b1;
            end else begin
               d.cmd_stop = 1'b1;
               if (q.tun_act && (q.cmd == `THL_CMD_RESULT_OK
                     || q.cmd == `THL_CMD_RESULT_ERR)) begin
                  d.tm = TM_OFF;
                  d.res_pend = 1'b1;
               end
            end
         end else if (q.rw) begin
            d.poll_fix = q.crd;
            d.crd = 1'b0;
            if (q.inq_rsp && q.hdr_cnt == 2'd0) begin
               d.inq_rsp = 1'b0;
               d.tm = TM_ANS;
               d.tcnt = 16'd0;
            end
            if (q.res_pend && !q.pend_ser) begin
               d.res_pend = 1'b0;
               d.res_send = 1'b1;
               d.tun_act = 1'b0;
            end
         end
      end
      if (start) begin
         d.st = ST_ADDR;
         d.bit_cnt = 4'd0;
         d.sda_oe = 1'b0;
      end
      // Sticky interrupts; a new event wins over the read-address clear
      d.pend_ser = (q.pend_ser && !clr_all) || cmd_done || (d.pend_ser && !q.pend_ser);
      d.pend_rf = (q.pend_rf && !clr_all && !q.mask_rf) || set_rf;
      d.pend_fld = (q.pend_fld && !clr_all && !q.mask_fld) || set_fld;
      d.pend_tun = (q.pend_tun && !clr_all) || tun_event;
      d.alert_oe = d.pend_ser || d.pend_rf || d.pend_fld || d.pend_tun;
      // Capture the tunnel command address on arrival
      if (tun_event) begin
         d.tun_act = 1'b1;
         d.hdr_hi = {`THL_TUN_MARK, tun_mode(tun_crypt, tun_family), tun_addr[11:8]};
         d.hdr_lo = tun_addr[7:0];
      end
      // Wait timers pause while a transfer is on the bus
      if (q.tm == TM_OFF && q.tun_act && !q.inq_rsp && !q.res_pend
            && q.alert_oe && !q.alert_prev) begin
         d.tm = TM_INQ;
         d.tcnt = 16'd0;
      end else if (q.tm != TM_OFF && q.st == ST_IDLE && tick) begin
         if (expired(q.tcnt, q.tm == TM_INQ ? inquiry_wait_limit : result_wait_limit)) begin
            d.tm = TM_OFF;
            d.tmo = 1'b1;
            d.tun_act = 1'b0;
         end else begin
            d.tcnt = q.tcnt + 16'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Buffer hookup and registered outputs
   assign push_s.valid = q.push_v;
   assign push_s.data = q.push_d;
   assign out_s.ready = rx_ready;
   assign rx_valid = out_s.valid;
   assign rx_data = out_s.data[7:0];
   assign rx_first = out_s.data[8];
   assign sda_o = 1'b0;
   assign sda_oe = q.sda_oe;
   assign host_alert_n_o = 1'b0;
   assign host_alert_n_oe = q.alert_oe;
   assign tx_ready = q.tx_ready;
   assign cmd_stop = q.cmd_stop;
   assign mask_rf = q.mask_rf;
   assign mask_fld = q.mask_fld;
   assign tun_result_send = q.res_send;
   assign tun_timeout = q.tmo;
endmodule : thl_host_link
`default_nettype wire

// ---- pkg/thl_cfg.svh ----
`ifndef THL_CFG_SVH
`define THL_CFG_SVH
// Host command codes
`define THL_CMD_INQUIRY 8'h28
`define THL_CMD_RESULT_OK 8'hF8
`define THL_CMD_RESULT_ERR 8'hE8
`define THL_CMD_CTRL_READ 8'h68
`define THL_CMD_CTRL_WRITE 8'h78
// Control-write data bit positions
`define THL_WR_MASK_RF 6
`define THL_WR_MASK_FLD 5
// Source-select bit positions
`define THL_SEL_FLD 0
`define THL_SEL_RF_SRC 1
`define THL_SEL_RF_EN 2
// Status nibbles forced after a control-read response
`define THL_NIB_BUSY 4'h7
`define THL_NIB_DIAG 4'hB
// Inquiry address upper-byte marks and mode codes
`define THL_TUN_MARK 2'b01
`define THL_MODE_PLAIN 2'b00
`define THL_MODE_PRIVATE 2'b10
`define THL_MODE_FAMILY 2'b11
// Timing: wait limits count ticks of 1 us
`define THL_CLK_NS 10
`define THL_TICK_NS 1000
`define THL_TICK_CYC (`THL_TICK_NS / `THL_CLK_NS)
// Response header length of an inquiry
`define THL_HDR_LEN 2'd3
`endif

// ---- pkg/thl_pkg.sv ----
package thl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT
   } thl_bus_st_t;

   typedef enum logic [1:0] {TM_OFF, TM_INQ, TM_ANS} thl_tmr_st_t;

   typedef struct packed {
      thl_bus_st_t st;
      thl_tmr_st_t tm;
      logic [3:0] bit_cnt;
      logic [7:0] sh;
      logic rw;
      logic first;
      logic second;
      logic [7:0] cmd;
      logic push_v;
      logic [8:0] push_d;
      logic sda_oe;
      logic alert_oe;
      logic alert_prev;
      logic pend_ser;
      logic pend_rf;
      logic pend_fld;
      logic pend_tun;
      logic mask_rf;
      logic mask_fld;
      logic fld_prev;
      logic scl_prev;
      logic sda_prev;
      logic crd;
      logic poll_fix;
      logic [1:0] hdr_cnt;
      logic [7:0] hdr_hi;
      logic [7:0] hdr_lo;
      logic inq_rsp;
      logic res_pend;
      logic tun_act;
      logic tx_ready;
      logic cmd_stop;
      logic res_send;
      logic tmo;
      logic [6:0] pre;
      logic [15:0] tcnt;
   } thl_main_t;
endpackage : thl_pkg

// ---- pkg/thl_stream_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface thl_stream_if #(parameter int W = 9) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport dst(input valid, input data, output ready);
endinterface : thl_stream_if
`default_nettype wire

// ---- hdl/thl_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module thl_pin_sync #(
   parameter int W = 2,
   parameter logic [W-1:0] RST = '1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } thl_sync_t;
   thl_sync_t q, d;

   // Three stages; a bit changes once stages two and three agree
   always_comb begin
      d = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.o[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= {RST, RST, RST, RST};
      end else begin
         q <= d;
      end
   end

   assign level = q.o;
endmodule : thl_pin_sync
`default_nettype wire

// ---- hdl/thl_pair_buf.sv ----
`timescale 1ns/10ps
`default_nettype none
module thl_pair_buf #(
   parameter int W = 9
) (
   input wire logic clk,
   input wire logic nrst,
   thl_stream_if.dst in_s,
   thl_stream_if.src out_s
);
   typedef struct packed {
      logic ov;
      logic [W-1:0] od;
      logic sv;
      logic [W-1:0] sd;
   } thl_buf_t;
   thl_buf_t q, d;
   logic push;
   logic pop;

   // Output slot plus one spare slot; ready drops only when both are full
   always_comb begin
      d = q;
      push = in_s.valid && !q.sv;
      pop = q.ov && out_s.ready;
      if (pop) begin
         if (q.sv) begin
            d.od = q.sd;
            d.sv = push;
            d.sd = in_s.data;
         end else begin
            d.ov = push;
            d.od = in_s.data;
         end
      end else if (push) begin
         if (!q.ov) begin
            d.ov = 1'b1;
            d.od = in_s.data;
         end else begin
            d.sv = 1'b1;
            d.sd = in_s.data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_s.ready = !q.sv;
   assign out_s.valid = q.ov;
   assign out_s.data = q.od;
endmodule : thl_pair_buf
`default_nettype wire

// ---- testbench/thl_host_link_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module thl_host_link_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic host_alert_n_o,
   input wire logic host_alert_n_oe,
   input wire logic [2:0] alert_source_select,
   input wire logic rf_resp_pulse,
   input wire logic rf_nv_write_done,
   input wire logic field_present,
   input wire logic cmd_done,
   input wire logic tun_event,
   input wire logic mask_rf,
   input wire logic mask_fld
);
   // Single clock domain, checks idle during reset except the reset-quiet check
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_alert_low_only; host_alert_n_o == 1'b0; endproperty
   a_alert_low_only: assert property (p_alert_low_only) else $error("alert pin driven high");
   property p_sda_low_only; sda_o == 1'b0; endproperty
   a_sda_low_only: assert property (p_sda_low_only) else $error("data pin driven high");
   property p_reset_quiet; disable iff (1'b0) !nrst |=> !host_alert_n_oe; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("alert active in reset");
   property p_done_alert; cmd_done |-> ##[1:2] host_alert_n_oe; endproperty
   a_done_alert: assert property (p_done_alert) else $error("no alert on completion");
   property p_tun_alert; tun_event |-> ##[1:2] host_alert_n_oe; endproperty
   a_tun_alert: assert property (p_tun_alert) else $error("no alert on tunnel");
   property p_rf_resp_alert;
      rf_resp_pulse && alert_source_select[2] && !alert_source_select[1] && !mask_rf
         |-> ##[1:2] host_alert_n_oe;
   endproperty
   a_rf_resp_alert: assert property (p_rf_resp_alert) else $error("no alert on response");
   property p_nv_alert;
      rf_nv_write_done && (alert_source_select[2:1] == 2'b11) && !mask_rf
         |-> ##[1:2] host_alert_n_oe;
   endproperty
   a_nv_alert: assert property (p_nv_alert) else $error("no alert on write done");
   property p_field_alert;
      $rose(field_present) && alert_source_select[0] && !mask_fld |-> ##[1:2] host_alert_n_oe;
   endproperty
   a_field_alert: assert property (p_field_alert) else $error("no alert on field");
   property p_rf_masked;
      mask_rf && (rf_resp_pulse || rf_nv_write_done) && !host_alert_n_oe && !cmd_done
         && !tun_event && !field_present |=> !host_alert_n_oe;
   endproperty
   a_rf_masked: assert property (p_rf_masked) else $error("masked source alerted");
   property p_fld_masked;
      mask_fld && $rose(field_present) && !host_alert_n_oe && !cmd_done && !tun_event
         && !rf_resp_pulse && !rf_nv_write_done |=> !host_alert_n_oe;
   endproperty
   a_fld_masked: assert property (p_fld_masked) else $error("masked field alerted");
   property p_alert_holds;
      (host_alert_n_oe && scl_i && sda_i) [*8] |=> host_alert_n_oe;
   endproperty
   a_alert_holds: assert property (p_alert_holds) else $error("alert dropped on idle bus");
endmodule : thl_host_link_asserts
bind thl_host_link thl_host_link_asserts thl_host_link_asserts_i (.clk, .nrst, .scl_i, .sda_i,
   .sda_o, .host_alert_n_o, .host_alert_n_oe, .alert_source_select, .rf_resp_pulse,
   .rf_nv_write_done, .field_present, .cmd_done, .tun_event, .mask_rf, .mask_fld);
`default_nettype wire

// ---- testbench/thl_i2c_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module thl_i2c_host (
   input wire logic clk,
   output logic scl,
   output logic sda_m,
   input wire logic sda_bus
);
   // Bus idles released high through the pull-up
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // One bus phase of eight clocks
   task automatic put(input logic c, input logic d);
      @(posedge clk);
      scl <= c;
      sda_m <= d;
      repeat (7) @(posedge clk);
   endtask : put
   // Data changes only while the clock is low
   task automatic bitx(input logic d, output logic s);
      put(1'b0, sda_m);
      put(1'b0, d);
      put(1'b1, d);
      #1 s = sda_bus;
   endtask : bitx
   task automatic start();
      put(1'b1, 1'b1);
      put(1'b1, 1'b0);
   endtask : start
   task automatic stop();
      put(1'b0, sda_m);
      put(1'b0, 1'b0);
      put(1'b1, 1'b0);
      put(1'b1, 1'b1);
      repeat (4) @(posedge clk);
   endtask : stop
   // Most significant bit first, then the acknowledge slot
   task automatic byte_wr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(b[i], s);
      bitx(1'b1, s);
      ack = !s;
   endtask : byte_wr
   task automatic byte_rd(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
      bitx(nack, s);
   endtask : byte_rd
endmodule : thl_i2c_host
`default_nettype wire

// ---- testbench/thl_host_link_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module thl_host_link_tb;
   import thl_pkg::*;
   logic clk = 1'b0;
   logic nrst, scl, sda_m, sda_oe, host_alert_n_oe, rf_resp_pulse, rf_nv_write_done;
   logic field_present, rf_busy, cmd_done, tun_event, tun_crypt, tun_family, rx_valid;
   logic rx_first, rx_ready, tx_ready, cmd_stop, mask_rf, mask_fld, tun_result_send, tun_timeout;
   logic [2:0] alert_source_select;
   logic [7:0] rx_data, status_byte, tx_data;
   logic tx_valid;
   logic [11:0] tun_addr;
   logic [15:0] inquiry_wait_limit;
   logic [7:0] n_stop = 8'h00, n_send = 8'h00, n_tmo = 8'h00, n_take = 8'h00, old;
   logic [7:0] r [3];
   logic [1:0] md [3] = '{2'b00, 2'b10, 2'b11};
   logic [7:0] code [3] = '{8'hF8, 8'hE8, 8'hF8};
   int n_mismatch = 0;
   int checks = 0;
   wire logic sda_bus = sda_m & ~sda_oe;
   thl_host_link thl_host_link_i (.clk, .nrst, .scl_i(scl), .sda_i(sda_bus), .sda_o(), .sda_oe,
      .host_alert_n_o(), .host_alert_n_oe, .alert_source_select, .inquiry_wait_limit,
      .result_wait_limit(16'h0014), .rf_resp_pulse, .rf_nv_write_done, .field_present, .rf_busy,
      .self_diag_err(1'b0), .status_byte, .cmd_done, .tun_event, .tun_crypt, .tun_family,
      .tun_addr, .rx_valid, .rx_data, .rx_first, .rx_ready, .tx_valid, .tx_data,
      .tx_ready, .cmd_stop, .mask_rf, .mask_fld, .tun_result_send, .tun_timeout);
   thl_i2c_host thl_i2c_host_i (.clk, .scl, .sda_m, .sda_bus);
   always #5 clk = ~clk;
   // Count one-cycle pulses
   always @(posedge clk) begin
      n_stop <= n_stop + 8'(cmd_stop);
      n_send <= n_send + 8'(tun_result_send);
      n_tmo <= n_tmo + 8'(tun_timeout);
      n_take <= n_take + 8'(tx_ready);
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   // Write transfer, every byte must be acknowledged
   task automatic send(input logic [7:0] b0, input logic [7:0] b1, input int n);
      logic s;
      thl_i2c_host_i.start();
      thl_i2c_host_i.byte_wr(8'hA0, s);
      check(s, 1);
      thl_i2c_host_i.byte_wr(b0, s);
      check(s, 1);
      if (n > 1) begin
         thl_i2c_host_i.byte_wr(b1, s);
         check(s, 1);
      end
      thl_i2c_host_i.stop();
   endtask : send
   // Read transfer, last byte not acknowledged
   task automatic recv(input int n);
      logic s;
      thl_i2c_host_i.start();
      thl_i2c_host_i.byte_wr(8'hA1, s);
      check(s, 1);
      check(host_alert_n_oe, 0);
      for (int i = 0; i < n; i++) thl_i2c_host_i.byte_rd(i == n - 1, r[i]);
      thl_i2c_host_i.stop();
   endtask : recv
   task automatic done_irq();
      @(posedge clk) cmd_done <= 1'b1;
      @(posedge clk) cmd_done <= 1'b0;
      @(posedge clk) #1 check(host_alert_n_oe, 1);
   endtask : done_irq
   task automatic irq_case(input logic [2:0] sel, input int src, input logic exp);
      @(posedge clk) alert_source_select <= sel;
      @(posedge clk);
      if (src == 0) rf_resp_pulse <= 1'b1;
      if (src == 1) rf_nv_write_done <= 1'b1;
      if (src == 2) field_present <= 1'b1;
      @(posedge clk);
      rf_resp_pulse <= 1'b0;
      rf_nv_write_done <= 1'b0;
      field_present <= 1'b0;
      @(posedge clk) #1 check(host_alert_n_oe, exp);
      if (exp) recv(1);
   endtask : irq_case
   // Stalled receiver keeps both command bytes
   task automatic t_cmd();
      @(posedge clk) rx_ready <= 1'b0;
      send(8'h18, 8'hA5, 2);
      check({rx_valid, rx_first}, 3);
      check(rx_data, 8'h18);
      check(n_stop, 1);
      @(posedge clk) rx_ready <= 1'b1;
      @(posedge clk) rx_ready <= 1'b0;
      #1 check({rx_valid, rx_first}, 2'b10);
      check(rx_data, 8'hA5);
      @(posedge clk) rx_ready <= 1'b1;
      done_irq();
      recv(1);
      check(r[0], status_byte);
   endtask : t_cmd
   task automatic t_irq();
      irq_case(3'b100, 0, 1);
      irq_case(3'b000, 0, 0);
      irq_case(3'b110, 1, 1);
      irq_case(3'b100, 1, 0);
      irq_case(3'b110, 0, 0);
      irq_case(3'b001, 2, 1);
      irq_case(3'b000, 2, 0);
      send(8'h78, 8'h60, 2);
      check({mask_rf, mask_fld}, 3);
      irq_case(3'b101, 0, 0);
      irq_case(3'b001, 2, 0);
      done_irq();
      recv(1);
      send(8'h78, 8'h00, 2);
      check({mask_rf, mask_fld}, 0);
   endtask : t_irq
   // First poll after a control read carries the busy or diagnosis nibble
   task automatic t_poll();
      for (int b = 0; b < 2; b++) begin
         send(8'h68, 8'h00, 1);
         done_irq();
         recv(2);
         @(posedge clk) rf_busy <= b[0];
         recv(1);
         check(r[0], {status_byte[7:4], b[0] ? 4'h7 : 4'hB});
         check(r[0][7:4], status_byte[7:4]);
         @(posedge clk) rf_busy <= 1'b0;
      end
      recv(1);
      check(r[0], status_byte);
      // Pending response stream byte replaces the plain status
      @(posedge clk) tx_valid <= 1'b1;
      recv(1);
      tx_valid <= 1'b0;
      check(r[0], tx_data);
      check(n_take, 1);
   endtask : t_poll
   task automatic t_tunnel();
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         tun_event <= 1'b1;
         tun_crypt <= (i != 0);
         tun_family <= (i == 2);
         @(posedge clk) tun_event <= 1'b0;
         @(posedge clk) #1 check(host_alert_n_oe, 1);
         send(8'h28, 8'h00, 1);
         recv(3);
         check(r[0], status_byte);
         check(r[1], {2'b01, md[i], 4'h3});
         check(r[2], 8'hA5);
         old = n_send;
         send(code[i], 8'h3C, 2);
         done_irq();
         check(n_send, old);
         recv(1);
         check(n_send, old + 8'h01);
      end
      check(n_tmo, 0);
   endtask : t_tunnel
   // First pass: no inquiry; second pass: inquiry read, then no result
   task automatic t_timeout();
      for (int k = 1; k < 3; k++) begin
         @(posedge clk) tun_event <= 1'b1;
         @(posedge clk) tun_event <= 1'b0;
         if (k == 2) begin
            send(8'h28, 8'h00, 1);
            recv(3);
         end
         for (int i = 0; i < 3000 && n_tmo != 8'(k); i++) @(posedge clk);
         check(n_tmo, 8'(k));
         recv(1);
      end
   endtask : t_timeout
   initial begin
      nrst = 1'b0;
      {rf_resp_pulse, rf_nv_write_done, field_present, rf_busy, cmd_done} = 5'h00;
      {tun_event, tun_crypt, tun_family, rx_ready} = 4'h1;
      {tx_valid, tx_data} = 9'h096;
      alert_source_select = 3'h0;
      status_byte = 8'h5C;
      tun_addr = 12'h3A5;
      inquiry_wait_limit = 16'h0014;
      repeat (20) @(posedge clk);
      check({sda_oe, host_alert_n_oe, rx_valid, tx_ready, cmd_stop, mask_rf, mask_fld}, 0);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      t_cmd();
      t_irq();
      t_poll();
      t_tunnel();
      t_timeout();
      summarize();
   end
   // Cut a hung run short
   initial begin
      repeat (90000) @(posedge clk);
      check(0, 1);
      summarize();
   end
endmodule : thl_host_link_tb
`default_nettype wire
